// *** nvm_access_map.svh ***
// Offsets, field positions, reset values and timing counts of the access controller
`ifndef NVM_ACCESS_MAP_SVH
`define NVM_ACCESS_MAP_SVH

// ==========================================================
// Register byte offsets
`define NVM_OFF_DATA_LOW   8'h00
`define NVM_OFF_ADDR_LOW   8'h04
`define NVM_OFF_DATA_HIGH  8'h08
`define NVM_OFF_ADDR_HIGH  8'h0c
`define NVM_OFF_CONTROL    8'h10
`define NVM_OFF_UNLOCK     8'h14
`define NVM_OFF_FLAG_TWO   8'h18

// ==========================================================
// Field positions
`define NVM_CTL_SPACE      7
`define NVM_CTL_ABORT      3
`define NVM_CTL_PERMIT     2
`define NVM_CTL_STORE      1
`define NVM_CTL_READ       0
`define NVM_FLAG_DONE      0

// ==========================================================
// Reset values and keys
`define NVM_RST_BYTE       8'h00
`define NVM_KEY_FIRST      8'h55
`define NVM_KEY_SECOND     8'haa

// ==========================================================
// Timing
`define NVM_CLK_PERIOD_NS  100
`define NVM_STORE_TIME_NS  5000
`define NVM_STORE_CYCLES   ((`NVM_STORE_TIME_NS + `NVM_CLK_PERIOD_NS - 1) / `NVM_CLK_PERIOD_NS)
`define NVM_DATA_RD_CYCLES 1
`define NVM_PROG_RD_CYCLES 2

`endif

// *** nvm_pkg.sv ***
// Types shared by the access controller
package nvm_pkg;

   // ==========================================================
   // Control register fields
   typedef struct packed {
      logic space_select;
      logic commit_abort_flag;
      logic commit_permit;
      logic store_req;
      logic read_req;
   } nvm_ctrl_type;

   // ==========================================================
   // External programmer read request
   typedef struct packed {
      logic        valid;
      logic        space;
      logic [12:0] addr;
   } ext_req_type;

   typedef enum logic [1:0] {
      st_idle,
      st_read,
      st_store
   } nvm_state_type;

endpackage

// *** nvm_access_ctrl.sv ***
// Data EEPROM and program flash access controller with AXI4-Lite registers
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "nvm_access_map.svh"

module nvm_access_ctrl
   import nvm_pkg::*;
#(
   parameter int PROG_DEPTH     = 4096,
   parameter int ADDR_HIGH_BITS = 5,
   parameter int STORE_CYCLES   = `NVM_STORE_CYCLES
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Reset causes that cut a store
   input  wire logic        master_clear_reset,
   input  wire logic        watchdog_reset,
   input  wire logic        brownout_reset,
   // Configuration
   input  wire logic [1:0]  self_program_protect,
   input  wire logic        code_protect,
   // External programmer port
   input  wire ext_req_type ext_req,
   output logic             ext_rd_valid,
   output logic [13:0]      ext_rd_data,
   output logic             ext_denied,
   // Status
   output logic             store_busy,
   // AXI4-Lite write
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   localparam int PA_W = $clog2(PROG_DEPTH);
   localparam logic [4:0] ADDR_HIGH_MASK = 5'((1 << ADDR_HIGH_BITS) - 1);
   localparam logic [15:0] STORE_LAST = 16'(STORE_CYCLES - 1);
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // Storage
   logic [7:0]    data_mem [0:255];
   logic [13:0]   prog_mem [0:PROG_DEPTH-1];

   logic [7:0]    data_low_reg;
   logic [7:0]    addr_low_reg;
   logic [5:0]    data_high_reg;
   logic [4:0]    addr_high_reg;
   nvm_ctrl_type  ctrl_reg;
   logic          done_flag_reg;
   logic [1:0]    unlock_reg;
   nvm_state_type state_reg;
   logic [15:0]   timer_reg;
   logic          st_space_reg;
   logic [12:0]   st_addr_reg;
   logic [13:0]   st_data_reg;

   logic          aw_full_reg;
   logic [7:0]    aw_addr_reg;
   logic          w_full_reg;
   logic [7:0]    w_data_reg;
   logic          w_lane_reg;

   // ==========================================================
   // Decode
   logic        wr_fire;
   logic        wr_lane;
   logic        wr_mapped;
   logic        wr_ctl;
   logic        wr_unlock;
   logic        wr_flag;
   logic [12:0] req_addr;
   logic        prog_blocked;
   logic        start_store;
   logic        start_read;
   logic        read_done;
   logic        store_done;
   logic        abort_evt;
   logic        abort_store;
   logic [15:0] read_last;

   assign wr_fire   = aw_full_reg & w_full_reg & ~s_axi_bvalid;
   assign wr_lane   = wr_fire & w_lane_reg;
   assign wr_ctl    = wr_lane & (aw_addr_reg == `NVM_OFF_CONTROL);
   assign wr_unlock = wr_lane & (aw_addr_reg == `NVM_OFF_UNLOCK);
   assign wr_flag   = wr_lane & (aw_addr_reg == `NVM_OFF_FLAG_TWO);

   always_comb begin
      wr_mapped = 1'b1;
      if (aw_addr_reg == `NVM_OFF_DATA_LOW) begin
         wr_mapped = 1'b1;
      end else if (aw_addr_reg == `NVM_OFF_ADDR_LOW) begin
         wr_mapped = 1'b1;
      end else if (aw_addr_reg == `NVM_OFF_DATA_HIGH) begin
         wr_mapped = 1'b1;
      end else if (aw_addr_reg == `NVM_OFF_ADDR_HIGH) begin
         wr_mapped = 1'b1;
      end else if (aw_addr_reg == `NVM_OFF_CONTROL) begin
         wr_mapped = 1'b1;
      end else if (aw_addr_reg == `NVM_OFF_UNLOCK) begin
         wr_mapped = 1'b1;
      end else if (aw_addr_reg == `NVM_OFF_FLAG_TWO) begin
         wr_mapped = 1'b1;
      end else begin
         wr_mapped = 1'b0;
      end
   end

   // Program address from both halves, data address from low only
   assign req_addr = {addr_high_reg, addr_low_reg};

   // Protect field: 11 none, 10 lowest 256, 01 lower half, 00 all
   always_comb begin
      case (self_program_protect)
         2'b11:   prog_blocked = 1'b0;
         2'b10:   prog_blocked = (req_addr < 13'd256);
         2'b01:   prog_blocked = (req_addr < 13'(PROG_DEPTH / 2));
         default: prog_blocked = 1'b1;
      endcase
   end

   // Store needs key pair, permit and an idle engine
   assign start_store = wr_ctl & w_data_reg[`NVM_CTL_STORE]
                      & w_data_reg[`NVM_CTL_PERMIT]
                      & (unlock_reg == 2'd2)
                      & (state_reg == st_idle)
                      & ~(w_data_reg[`NVM_CTL_SPACE] & prog_blocked);
   assign start_read  = wr_ctl & w_data_reg[`NVM_CTL_READ]
                      & (state_reg == st_idle) & ~start_store;

   assign read_last   = st_space_reg ? 16'(`NVM_PROG_RD_CYCLES - 1)
                                     : 16'(`NVM_DATA_RD_CYCLES - 1);
   assign read_done   = (state_reg == st_read) & (timer_reg == read_last);
   assign abort_evt   = master_clear_reset | watchdog_reset | brownout_reset;
   assign abort_store = (state_reg == st_store) & abort_evt;
   assign store_done  = (state_reg == st_store) & ~abort_evt
                      & (timer_reg == STORE_LAST);

   // ==========================================================
   // Operation engine
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= st_idle;
         timer_reg    <= 16'h0000;
         st_space_reg <= 1'b0;
         st_addr_reg  <= 13'h0000;
         st_data_reg  <= 14'h0000;
      end else begin
         case (state_reg)
            st_idle: begin
               timer_reg <= 16'h0000;
               if (start_store || start_read) begin
                  st_space_reg <= w_data_reg[`NVM_CTL_SPACE];
                  st_addr_reg  <= req_addr;
                  st_data_reg  <= {data_high_reg, data_low_reg};
                  state_reg    <= start_store ? st_store : st_read;
               end
            end
            st_read: begin
               timer_reg <= timer_reg + 16'h0001;
               if (read_done) begin
                  state_reg <= st_idle;
               end
            end
            st_store: begin
               timer_reg <= timer_reg + 16'h0001;
               if (store_done || abort_store) begin
                  state_reg <= st_idle;
               end
            end
            default: state_reg <= st_idle;
         endcase
      end
   end

   // Array writes; one timed cycle covers erase and program
   always_ff @(posedge clk) begin
      if (store_done) begin
         if (st_space_reg) begin
            prog_mem[st_addr_reg[PA_W-1:0]] <= st_data_reg;
         end else begin
            data_mem[st_addr_reg[7:0]] <= st_data_reg[7:0];
         end
      end
   end

   // ==========================================================
   // Unlock sequence; any other write breaks it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         unlock_reg <= 2'd0;
      end else if (wr_unlock) begin
         if (w_data_reg == `NVM_KEY_FIRST) begin
            unlock_reg <= 2'd1;
         end else if (w_data_reg == `NVM_KEY_SECOND && unlock_reg == 2'd1) begin
            unlock_reg <= 2'd2;
         end else begin
            unlock_reg <= 2'd0;
         end
      end else if (wr_fire) begin
         unlock_reg <= 2'd0;
      end
   end

   // ==========================================================
   // Control register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= '0;
      end else begin
         if (wr_ctl) begin
            ctrl_reg.space_select  <= w_data_reg[`NVM_CTL_SPACE];
            ctrl_reg.commit_permit <= w_data_reg[`NVM_CTL_PERMIT];
         end
         // Abort set wins over a software write
         if (abort_store) begin
            ctrl_reg.commit_abort_flag <= 1'b1;
         end else if (wr_ctl) begin
            ctrl_reg.commit_abort_flag <= w_data_reg[`NVM_CTL_ABORT];
         end
         // Set-only; zero writes do nothing
         if (start_store) begin
            ctrl_reg.store_req <= 1'b1;
         end else if (store_done || abort_store) begin
            ctrl_reg.store_req <= 1'b0;
         end
         if (start_read) begin
            ctrl_reg.read_req <= 1'b1;
         end else if (read_done) begin
            ctrl_reg.read_req <= 1'b0;
         end
      end
   end

   // Completion flag, sticky; hardware set wins over clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done_flag_reg <= 1'b0;
      end else if (store_done) begin
         done_flag_reg <= 1'b1;
      end else if (wr_flag) begin
         done_flag_reg <= w_data_reg[`NVM_FLAG_DONE];
      end
   end

   // ==========================================================
   // Address and data registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_low_reg  <= `NVM_RST_BYTE;
         addr_high_reg <= 5'h00;
      end else begin
         if (wr_lane && aw_addr_reg == `NVM_OFF_ADDR_LOW) begin
            addr_low_reg <= w_data_reg;
         end
         if (wr_lane && aw_addr_reg == `NVM_OFF_ADDR_HIGH) begin
            addr_high_reg <= w_data_reg[4:0] & ADDR_HIGH_MASK;
         end
      end
   end

   // Read result wins over a software write in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_low_reg  <= `NVM_RST_BYTE;
         data_high_reg <= 6'h00;
      end else if (read_done) begin
         if (st_space_reg) begin
            data_low_reg  <= prog_mem[st_addr_reg[PA_W-1:0]][7:0];
            data_high_reg <= prog_mem[st_addr_reg[PA_W-1:0]][13:8];
         end else begin
            data_low_reg <= data_mem[st_addr_reg[7:0]];
         end
      end else begin
         if (wr_lane && aw_addr_reg == `NVM_OFF_DATA_LOW) begin
            data_low_reg <= w_data_reg;
         end
         if (wr_lane && aw_addr_reg == `NVM_OFF_DATA_HIGH) begin
            data_high_reg <= w_data_reg[5:0];
         end
      end
   end

   // ==========================================================
   // External programmer; locked out under code protection
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_rd_valid <= 1'b0;
         ext_rd_data  <= 14'h0000;
         ext_denied   <= 1'b0;
      end else begin
         ext_rd_valid <= ext_req.valid & ~code_protect;
         ext_denied   <= ext_req.valid & code_protect;
         if (ext_req.valid && !code_protect) begin
            ext_rd_data <= ext_req.space ? prog_mem[ext_req.addr[PA_W-1:0]]
                                         : {6'h00, data_mem[ext_req.addr[7:0]]};
         end else begin
            ext_rd_data <= 14'h0000;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         store_busy <= 1'b0;
      end else begin
         store_busy <= start_store | ((state_reg == st_store) & ~store_done & ~abort_store);
      end
   end

   // ==========================================================
   // AXI4-Lite write channels, taken in either order
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_full_reg   <= 1'b0;
         aw_addr_reg   <= 8'h00;
         s_axi_awready <= 1'b0;
         w_full_reg    <= 1'b0;
         w_data_reg    <= 8'h00;
         w_lane_reg    <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg   <= 1'b1;
            aw_addr_reg   <= {s_axi_awaddr[7:2], 2'b00};
            s_axi_awready <= 1'b0;
         end else if (!aw_full_reg) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg   <= 1'b1;
            w_data_reg   <= s_axi_wdata[7:0];
            w_lane_reg   <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end else if (!w_full_reg) begin
            s_axi_wready <= 1'b1;
         end
         if (wr_fire) begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // AXI4-Lite read channel
   logic [7:0] rd_value;
   logic       rd_mapped;
   logic [7:0] rd_addr;

   assign rd_addr = {s_axi_araddr[7:2], 2'b00};

   always_comb begin
      rd_value  = 8'h00;
      rd_mapped = 1'b1;
      if (rd_addr == `NVM_OFF_DATA_LOW) begin
         rd_value = data_low_reg;
      end else if (rd_addr == `NVM_OFF_ADDR_LOW) begin
         rd_value = addr_low_reg;
      end else if (rd_addr == `NVM_OFF_DATA_HIGH) begin
         rd_value = {2'b00, data_high_reg};
      end else if (rd_addr == `NVM_OFF_ADDR_HIGH) begin
         rd_value = {3'b000, addr_high_reg};
      end else if (rd_addr == `NVM_OFF_CONTROL) begin
         rd_value = {ctrl_reg.space_select, 3'b000, ctrl_reg.commit_abort_flag,
                     ctrl_reg.commit_permit, ctrl_reg.store_req, ctrl_reg.read_req};
      end else if (rd_addr == `NVM_OFF_UNLOCK) begin
         rd_value = 8'h00;
      end else if (rd_addr == `NVM_OFF_FLAG_TWO) begin
         rd_value = {7'h00, done_flag_reg};
      end else begin
         rd_mapped = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h000000, rd_value};
         s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

endmodule
`default_nettype wire

// *** ext_prog_model.sv ***
// External programmer model driving the read request port
`timescale 1ns/1ps
`default_nettype none
module ext_prog_model
   import nvm_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Bench command
   input  wire logic        go,
   input  wire logic        space,
   input  wire logic [12:0] addr,
   // Request toward the controller
   output ext_req_type      ext_req
);
   // ==========================
   // Request register
   // Idle address keeps toggling so a stale value is never mistaken for a live one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_req <= '0;
      end else begin
         ext_req.valid <= go;
         ext_req.space <= space;
         ext_req.addr  <= go ? addr : ~ext_req.addr;
      end
   end
endmodule
`default_nettype wire

// *** nvm_access_assertions.sv ***
// Assertion checker for the access controller
`timescale 1ns/1ps
`default_nettype none
module nvm_access_checker
   import nvm_pkg::*;
#(
   parameter int STORE_CYCLES = 3
) (
   // Clock, reset, causes
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        master_clear_reset,
   input wire logic        watchdog_reset,
   input wire logic        brownout_reset,
   // Programmer port and store status
   input wire logic        code_protect,
   input wire ext_req_type ext_req,
   input wire logic        ext_rd_valid,
   input wire logic [13:0] ext_rd_data,
   input wire logic        ext_denied,
   input wire logic        store_busy,
   // Read channel
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   int   busy_cnt;
   logic cause;
   assign cause = master_clear_reset | watchdog_reset | brownout_reset;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) busy_cnt <= 0;
      else busy_cnt <= store_busy ? busy_cnt + 1 : 0;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========================
   // Properties
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   rd_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read not released");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("address taken during answer");
   unmapped_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h06
      |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read answered");
   store_len_a: assert property (busy_cnt <= STORE_CYCLES + 1) else $error("store overran its timer");
   abort_end_a: assert property (store_busy && cause |-> ##[1:2] !store_busy) else $error("store not cut");
   ext_deny_a: assert property (ext_req.valid && code_protect
      |=> ext_denied && !ext_rd_valid && ext_rd_data == 14'h0) else $error("programmer not denied");
   ext_read_a: assert property (ext_req.valid && !code_protect |=> ext_rd_valid && !ext_denied)
      else $error("programmer read missing");
   pulse_once_a: assert property (ext_rd_valid |=> !ext_rd_valid) else $error("read pulse too long");
   store_done_c: cover property ($fell(store_busy) && !cause);
   store_cut_c: cover property (store_busy && cause);
   denied_c: cover property (ext_denied);
endmodule
bind nvm_access_ctrl nvm_access_checker #(.STORE_CYCLES(STORE_CYCLES)) nvm_access_checker_inst (.*);
`default_nettype wire

// *** nvm_access_ctrl_tb.sv ***
// Self-checking bench for the access controller
`timescale 1ns/1ps
`default_nettype none
`include "nvm_access_map.svh"
module nvm_access_ctrl_tb
   import nvm_pkg::*;
;
   // ==========================
   // Signals
   logic        clk = 1'b0, rst_n = 1'b0, code_protect = 1'b0;
   logic        master_clear_reset = 1'b0, watchdog_reset = 1'b0, brownout_reset = 1'b0;
   logic [1:0]  self_program_protect = 2'b11, s_axi_bresp, s_axi_rresp, rsp;
   ext_req_type ext_req;
   logic        ext_rd_valid, ext_denied, store_busy, go = 1'b0;
   logic [13:0] ext_rd_data;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, a, d, h;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
   logic [3:0]  s_axi_wstrb = 4'h1;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int          bad_count = 0, check_count = 0;
   always #50 clk = ~clk;
   nvm_access_ctrl #(.STORE_CYCLES(20)) nvm_access_ctrl_inst (.*);
   ext_prog_model ext_prog_model_inst (.clk(clk), .rst_n(rst_n), .go(go), .space(1'b1), .addr({5'h0a, a}),
      .ext_req(ext_req));
   // ==========================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      @(posedge clk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= {24'h0, dt};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] ad, input logic [31:0] exp, input string nm);
      @(posedge clk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      v = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (nm != "") chk(nm, v, exp);
   endtask
   task automatic store(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] ctl);
      wr(`NVM_OFF_UNLOCK, k1);
      wr(`NVM_OFF_UNLOCK, k2);
      wr(`NVM_OFF_CONTROL, ctl);
   endtask
   task automatic wait_store;
      for (int n = 0; n < 100; n++) begin
         rc(`NVM_OFF_CONTROL, 32'h0, "");
         if (v[1] === 1'b0) break;
      end
   endtask
   task automatic ext_chk(input logic [13:0] exp, input logic [1:0] flags);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      chk("ext data", {18'h0, ext_rd_data}, {18'h0, exp});
      chk("ext flags", {30'h0, ext_rd_valid, ext_denied}, {30'h0, flags});
      @(posedge clk);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Run limit of 20000 cycles, well above the several hundred cycles the sequence needs
   initial begin
      #(100 * 20000);
      bad_count++;
      stop_test();
   end
   // ==========================
   // Sequence
   initial begin
      void'($urandom(22581));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      for (int i = 0; i < 7; i++) rc(8'(i * 4), 32'h0, "reset value");
      rc(8'h1c, 32'h0, "unmapped");
      chk("unmapped resp", {30'h0, rsp}, 32'h2);
      wr(8'h1c, 8'h5a);
      chk("unmapped wresp", {30'h0, rsp}, 32'h2);
      wr(`NVM_OFF_DATA_HIGH, 8'hff);
      chk("mapped wresp", {30'h0, rsp}, 32'h0);
      rc(`NVM_OFF_DATA_HIGH, 32'h3f, "data high");
      s_axi_wstrb <= 4'h0;
      wr(`NVM_OFF_DATA_HIGH, 8'h00);
      s_axi_wstrb <= 4'h1;
      rc(`NVM_OFF_DATA_HIGH, 32'h3f, "strobe off");
      wr(`NVM_OFF_ADDR_HIGH, 8'hff);
      rc(`NVM_OFF_ADDR_HIGH, 32'h1f, "addr high");
      wr(`NVM_OFF_CONTROL, 8'h70);
      rc(`NVM_OFF_CONTROL, 32'h0, "control spare");
      wr(`NVM_OFF_UNLOCK, 8'h5a);
      rc(`NVM_OFF_UNLOCK, 32'h0, "unlock port");
      wr(`NVM_OFF_ADDR_HIGH, 8'h00);
      for (int i = 0; i < 4; i++) begin
         a = (i == 0) ? 8'hff : 8'($urandom);
         d = 8'($urandom);
         wr(`NVM_OFF_ADDR_LOW, a);
         wr(`NVM_OFF_DATA_LOW, d);
         store(`NVM_KEY_FIRST, `NVM_KEY_SECOND, 8'h06);
         rc(`NVM_OFF_CONTROL, 32'h06, "store running");
         chk("store busy", {31'h0, store_busy}, 32'h1);
         wr(`NVM_OFF_CONTROL, 8'h05);
         rc(`NVM_OFF_CONTROL, 32'h06, "read while busy");
         wait_store();
         rc(`NVM_OFF_FLAG_TWO, 32'h1, "done flag");
         wr(`NVM_OFF_FLAG_TWO, 8'h00);
         rc(`NVM_OFF_FLAG_TWO, 32'h0, "done flag clear");
         wr(`NVM_OFF_DATA_LOW, ~d);
         wr(`NVM_OFF_CONTROL, 8'h01);
         rc(`NVM_OFF_DATA_LOW, {24'h0, d}, "stored byte");
         rc(`NVM_OFF_CONTROL, 32'h0, "read bit clear");
      end
      // Wrong key order, missing keys and missing permit must all be refused
      store(`NVM_KEY_SECOND, `NVM_KEY_FIRST, 8'h06);
      rc(`NVM_OFF_CONTROL, 32'h04, "keys swapped");
      wr(`NVM_OFF_CONTROL, 8'h06);
      rc(`NVM_OFF_CONTROL, 32'h04, "no keys");
      store(`NVM_KEY_FIRST, `NVM_KEY_SECOND, 8'h02);
      rc(`NVM_OFF_CONTROL, 32'h0, "no permit");
      for (int i = 0; i < 3; i++) begin
         wr(`NVM_OFF_DATA_LOW, ~d);
         store(`NVM_KEY_FIRST, `NVM_KEY_SECOND, 8'h06);
         {master_clear_reset, watchdog_reset, brownout_reset} <= 3'b100 >> i;
         @(posedge clk);
         {master_clear_reset, watchdog_reset, brownout_reset} <= 3'b000;
         rc(`NVM_OFF_CONTROL, 32'h0c, "abort flag");
         wr(`NVM_OFF_CONTROL, 8'h01);
         rc(`NVM_OFF_DATA_LOW, {24'h0, d}, "aborted byte");
      end
      a = 8'($urandom);
      d = 8'($urandom);
      h = 8'($urandom) & 8'h3f;
      wr(`NVM_OFF_ADDR_HIGH, 8'h0a);
      wr(`NVM_OFF_ADDR_LOW, a);
      wr(`NVM_OFF_DATA_HIGH, h);
      wr(`NVM_OFF_DATA_LOW, d);
      store(`NVM_KEY_FIRST, `NVM_KEY_SECOND, 8'h86);
      wait_store();
      wr(`NVM_OFF_DATA_LOW, 8'h00);
      wr(`NVM_OFF_DATA_HIGH, 8'h00);
      wr(`NVM_OFF_CONTROL, 8'h81);
      rc(`NVM_OFF_DATA_LOW, {24'h0, d}, "entry low");
      rc(`NVM_OFF_DATA_HIGH, {24'h0, h}, "entry high");
      // Low addresses fall inside every protected region
      wr(`NVM_OFF_ADDR_HIGH, 8'h00);
      for (int i = 0; i < 3; i++) begin
         self_program_protect <= 2'(i);
         store(`NVM_KEY_FIRST, `NVM_KEY_SECOND, 8'h86);
         rc(`NVM_OFF_CONTROL, 32'h84, "protected store");
      end
      ext_chk({h[5:0], d}, 2'b10);
      code_protect <= 1'b1;
      ext_chk(14'h0, 2'b01);
      stop_test();
   end
endmodule
`default_nettype wire
